// [shared/bdh_params.svh]
// Busy duration histogram: addresses, field positions, reset values and counts
// Assumes byte addresses of the board register window, 24 bits wide
`ifndef BDH_PARAMS_SVH
`define BDH_PARAMS_SVH

`define BDH_ADDR_W        24
`define BDH_CTRL_ADDR     24'hc0001c
`define BDH_STAT_ADDR     24'hc0005c
`define BDH_RAM_BASE      24'hc01000
`define BDH_RAM_LAST      24'hc01ffc
`define BDH_CTRL_EN_BIT   0
`define BDH_CTRL_MODE_BIT 1
`define BDH_CTRL_RESET    2'h0
`define BDH_STAT_PTR_LSB  0
`define BDH_STAT_WRAP_LSB 10
`define BDH_TERM_COUNT    65636
`define BDH_RAM_DEPTH     1024
`define BDH_BIN_W         16
`define BDH_WRAP_W        6

`endif

// [shared/bdh_pkg.sv]
// Busy duration histogram: shared types
// Assumes bdh_params.svh is on the include path
package bdh_pkg;
    typedef enum logic [1:0] {
        BDH_IDLE  = 2'b00,
        BDH_ARM   = 2'b01,
        BDH_RUN   = 2'b10,
        BDH_CLEAR = 2'b11
    } bdh_state_t;

    typedef logic [31:0] bdh_word_t;
endpackage

// [src/bdh_busy_histogram.sv]
// Busy duration histogram engine with its control/status registers and record RAM
// Assumes a synchronous register port on clk, one access at a time, answered with reg_ack
`include "bdh_params.svh"

module bdh_busy_histogram #(
    parameter int TERM_COUNT = `BDH_TERM_COUNT,
    parameter int RAM_DEPTH  = `BDH_RAM_DEPTH
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // Board events
    input  wire logic                   board_busy_signal,
    input  wire logic                   level_one_accept,
    input  wire logic                   global_clear,
    // Register port
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [`BDH_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]            reg_wdata,
    output logic      [31:0]            reg_rdata,
    output logic                        reg_ack
);
    localparam int AW = $clog2(RAM_DEPTH);
    localparam int CW = $clog2(TERM_COUNT);
    localparam logic [CW-1:0] TC_LAST = CW'(TERM_COUNT - 1);
    localparam logic [`BDH_BIN_W-1:0] BIN_MAX = '1;
    localparam logic [AW-1:0] ADDR_LAST = AW'(RAM_DEPTH - 1);

    function automatic logic is_ram(input logic [`BDH_ADDR_W-1:0] a);
        is_ram = (a >= `BDH_RAM_BASE) && (a <= `BDH_RAM_LAST) && (a[1:0] == 2'h0);
    endfunction

    bdh_pkg::bdh_state_t       state_r;
    logic [1:0]                ctrl_r;
    logic [CW-1:0]             bin_r;
    logic [`BDH_BIN_W-1:0]     busy_r;
    logic [`BDH_BIN_W-1:0]     hold_r;
    logic                      phase_r;
    logic [AW-1:0]             wr_ptr_r;
    logic [AW-1:0]             clr_ptr_r;
    logic [`BDH_WRAP_W-1:0]    wrap_r;
    bdh_pkg::bdh_word_t        mem [RAM_DEPTH];

    logic                      en;
    logic                      trig_mode;
    logic                      running;
    logic                      tc;
    logic [`BDH_BIN_W-1:0]     busy_sum;
    logic                      ram_we;
    logic [AW-1:0]             ram_waddr;
    bdh_pkg::bdh_word_t        ram_wdata;
    logic [AW-1:0]             rd_idx;

    assign en        = ctrl_r[`BDH_CTRL_EN_BIT];
    assign trig_mode = ctrl_r[`BDH_CTRL_MODE_BIT];
    assign running   = (state_r == bdh_pkg::BDH_RUN) && en && !global_clear;
    assign tc        = running && (bin_r == TC_LAST);
    // Includes the busy sample of the terminal cycle itself
    assign busy_sum  = (board_busy_signal && busy_r != BIN_MAX) ? busy_r + 1'b1 : busy_r;
    assign rd_idx    = AW'((reg_addr - `BDH_RAM_BASE) >> 2);

    // Control register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            ctrl_r <= `BDH_CTRL_RESET;
        else if (reg_wr && reg_addr == `BDH_CTRL_ADDR)
            ctrl_r <= reg_wdata[1:0];
    end

    // Engine sequencing
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= bdh_pkg::BDH_IDLE;
        end else if (global_clear) begin
            state_r <= bdh_pkg::BDH_CLEAR;
        end else begin
            case (state_r)
                bdh_pkg::BDH_CLEAR:
                    if (clr_ptr_r == ADDR_LAST)
                        state_r <= bdh_pkg::BDH_IDLE;
                bdh_pkg::BDH_IDLE:
                    if (en)
                        state_r <= trig_mode ? bdh_pkg::BDH_ARM : bdh_pkg::BDH_RUN;
                bdh_pkg::BDH_ARM:
                    if (!en)
                        state_r <= bdh_pkg::BDH_IDLE;
                    else if (level_one_accept)
                        state_r <= bdh_pkg::BDH_RUN;
                bdh_pkg::BDH_RUN:
                    if (!en)
                        state_r <= bdh_pkg::BDH_IDLE;
                default:
                    state_r <= bdh_pkg::BDH_IDLE;
            endcase
        end
    end

    // Interval counters and pairing
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bin_r   <= '0;
            busy_r  <= '0;
            hold_r  <= '0;
            phase_r <= 1'b0;
        end else if (!running) begin
            bin_r   <= '0;
            busy_r  <= '0;
            phase_r <= 1'b0;
            if (global_clear)
                hold_r <= '0;
        end else if (tc) begin
            bin_r   <= '0;
            busy_r  <= '0;
            phase_r <= !phase_r;
            if (!phase_r)
                hold_r <= busy_sum;
        end else begin
            bin_r  <= bin_r + 1'b1;
            busy_r <= busy_sum;
        end
    end

    // Write pointer and wrap count
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_r <= '0;
            wrap_r   <= '0;
        end else if (global_clear) begin
            wr_ptr_r <= '0;
            wrap_r   <= '0;
        end else if (tc && phase_r) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
            if (wr_ptr_r == ADDR_LAST)
                wrap_r <= wrap_r + 1'b1;
        end
    end

    // Clear sweep pointer; the sweep takes one clock per word
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            clr_ptr_r <= '0;
        else if (global_clear)
            clr_ptr_r <= '0;
        else if (state_r == bdh_pkg::BDH_CLEAR)
            clr_ptr_r <= clr_ptr_r + 1'b1;
    end

    assign ram_we    = (tc && phase_r) || (state_r == bdh_pkg::BDH_CLEAR && !global_clear);
    assign ram_waddr = (state_r == bdh_pkg::BDH_CLEAR) ? clr_ptr_r : wr_ptr_r;
    assign ram_wdata = (state_r == bdh_pkg::BDH_CLEAR) ? '0 : {busy_sum, hold_r};

    // Record RAM, one write port and one host read port
    always_ff @(posedge clk) begin
        if (ram_we)
            mem[ram_waddr] <= ram_wdata;
    end

    // Register port: answer one clock after the request; unmapped reads give zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_ack   <= 1'b0;
            reg_rdata <= '0;
        end else begin
            reg_ack <= reg_rd || reg_wr;
            if (reg_rd) begin
                if (reg_addr == `BDH_CTRL_ADDR)
                    reg_rdata <= {30'h0, ctrl_r};
                else if (reg_addr == `BDH_STAT_ADDR)
                    reg_rdata <= {16'h0, wrap_r, wr_ptr_r};
                else if (is_ram(reg_addr))
                    reg_rdata <= mem[rd_idx];
                else
                    reg_rdata <= '0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    bin_wrap_a:     assert property (tc |=> bin_r == '0) else $error("bin counter not cleared at terminal");
    busy_step_a:    assert property (running && !tc && board_busy_signal && busy_r != BIN_MAX
                        |=> busy_r == $past(busy_r) + 1'b1) else $error("busy count did not step");
    busy_hold_a:    assert property (running && !tc && !board_busy_signal |=> $stable(busy_r))
                        else $error("busy count moved without busy");
    arm_idle_a:     assert property (state_r == bdh_pkg::BDH_ARM ##1 state_r == bdh_pkg::BDH_ARM
                        |-> bin_r == '0 && busy_r == '0) else $error("counters moved before trigger");
    arm_start_a:    assert property (state_r == bdh_pkg::BDH_ARM && en && level_one_accept && !global_clear
                        |=> state_r == bdh_pkg::BDH_RUN) else $error("trigger did not start");
    hold_latch_a:   assert property (tc && !phase_r |=> hold_r == $past(busy_sum) && busy_r == '0 && phase_r)
                        else $error("first interval not held");
    pair_word_a:    assert property (tc && phase_r |=> mem[$past(wr_ptr_r)] == {$past(busy_sum), $past(hold_r)})
                        else $error("record word wrong");
    ptr_step_a:     assert property (tc && phase_r |=> wr_ptr_r == $past(wr_ptr_r) + 1'b1 && !phase_r)
                        else $error("write address did not advance");
    auto_start_a:   assert property (state_r == bdh_pkg::BDH_IDLE && en && !trig_mode && !global_clear
                        |=> state_r == bdh_pkg::BDH_RUN) else $error("auto mode did not start");
    stop_a:         assert property (!en && !global_clear && state_r != bdh_pkg::BDH_CLEAR
                        |=> state_r == bdh_pkg::BDH_IDLE ##1 bin_r == '0) else $error("disable ignored");
    status_read_a:  assert property (reg_rd && reg_addr == `BDH_STAT_ADDR
                        |=> reg_ack && reg_rdata[15:0] == {$past(wrap_r), $past(wr_ptr_r)})
                        else $error("status read wrong");
    wrap_count_a:   assert property (tc && phase_r && wr_ptr_r == ADDR_LAST |=> wrap_r == $past(wrap_r) + 1'b1)
                        else $error("wrap not counted");
    clear_sweep_a:  assert property (global_clear |=> state_r == bdh_pkg::BDH_CLEAR && wr_ptr_r == '0
                        && wrap_r == '0 && clr_ptr_r == '0) else $error("global clear ignored");
    busy_sat_a:     assert property (running && !tc && busy_r == BIN_MAX |=> busy_r == BIN_MAX)
                        else $error("busy count wrapped");

    pair_write_c:   cover property (tc && phase_r);
    trig_start_c:   cover property (state_r == bdh_pkg::BDH_ARM ##1 state_r == bdh_pkg::BDH_RUN);
    wrap_c:         cover property (tc && phase_r && wr_ptr_r == ADDR_LAST);
    clear_done_c:   cover property (state_r == bdh_pkg::BDH_CLEAR ##1 state_r == bdh_pkg::BDH_IDLE);
endmodule // bdh_busy_histogram

// [test/bdh_host_model.sv]
// Host model for the histogram register port: single reads and writes, read data check
// Assumes strobes sampled on the rising clk edge and reg_ack one clock later
`include "bdh_params.svh"
module bdh_host_model (
    // Clock
    input  wire logic                   clk,
    // Register port
    output logic                        reg_wr,
    output logic                        reg_rd,
    output logic      [`BDH_ADDR_W-1:0] reg_addr,
    output logic      [31:0]            reg_wdata,
    input  wire logic [31:0]            reg_rdata,
    input  wire logic                   reg_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    int                 n_mismatch = 0;
    int                 n_tests    = 0;
    logic               was_rd     = 1'b0;
    bdh_pkg::bdh_word_t exp_q[$];
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
    end
    // One access; a read notes its expected word. Address held until the next access
    task automatic access(input logic wr, input logic [`BDH_ADDR_W-1:0] a, input bdh_pkg::bdh_word_t d);
        int i;
        reg_wr    <= wr;
        reg_rd    <= ~wr;
        reg_addr  <= a;
        reg_wdata <= wr ? d : ~d;
        if (!wr) exp_q.push_back(d);
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        for (i = 0; i < 4 && reg_ack !== 1'b1; i++) @(posedge clk);
        if (reg_ack !== 1'b1) begin
            n_mismatch++;
            testbench.final_report();
        end
    endtask
    task automatic cmp_word(input bdh_pkg::bdh_word_t got, input bdh_pkg::bdh_word_t exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read data is only valid in the ack cycle that answers a read
    always @(posedge clk) begin
        if (reg_ack === 1'b1 && was_rd) begin
            cmp_word(reg_rdata, exp_q.size() ? exp_q.pop_front() : ~reg_rdata);
        end
        was_rd <= reg_rd;
    end
endmodule // bdh_host_model

// [test/testbench.sv]
// Top-level bench: histogram engine with the host model on its register port
// Assumes TERM_COUNT shortened to 8, so one record takes 16 clocks
`include "bdh_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 8;
    logic                   clk = 1'b0;
    logic                   sys_rst = 1'b1;
    logic                   board_busy_signal = 1'b0;
    logic                   level_one_accept = 1'b0;
    logic                   global_clear = 1'b0;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [`BDH_ADDR_W-1:0] reg_addr;
    logic [31:0]            reg_wdata;
    logic [31:0]            reg_rdata;
    logic                   reg_ack;
    logic [31:0]            lfsr = 32'h2cde3828;
    int                     s0;
    int                     s1;
    bdh_busy_histogram #(.TERM_COUNT(TC)) bdh_busy_histogram_i (.clk(clk), .sys_rst(sys_rst),
        .board_busy_signal(board_busy_signal), .level_one_accept(level_one_accept),
        .global_clear(global_clear), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));
    bdh_host_model bdh_host_model_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));
    initial forever #2.5 clk = ~clk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Random busy over one interval pair; busy left high so idle phases would show any stray count
    task automatic run_pair(output int c0, output int c1);
        int i;
        c0 = 0;
        c1 = 0;
        for (i = 0; i < 2 * TC; i++) begin
            lfsr = lfsr_next(lfsr);
            board_busy_signal <= lfsr[0];
            if (i < TC) c0 += lfsr[0];
            else c1 += lfsr[0];
            @(posedge clk);
        end
        board_busy_signal <= 1'b1;
    endtask
    task automatic clear_all();
        global_clear <= 1'b1;
        @(posedge clk);
        global_clear <= 1'b0;
        repeat (1030) @(posedge clk);
    endtask
    task automatic final_report();
        if (bdh_host_model_i.n_mismatch == 0 && bdh_host_model_i.n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        bdh_host_model_i.access(1'b0, `BDH_CTRL_ADDR, 32'h0);
        clear_all();
        bdh_host_model_i.access(1'b0, `BDH_STAT_ADDR, 32'h0);
        bdh_host_model_i.access(1'b0, 24'hc00000, 32'h0);
        bdh_host_model_i.access(1'b0, 24'hc01002, 32'h0);
        board_busy_signal <= 1'b1;
        bdh_host_model_i.access(1'b1, `BDH_CTRL_ADDR, 32'h1);
        run_pair(s0, s1);
        bdh_host_model_i.access(1'b1, `BDH_CTRL_ADDR, 32'h0);
        bdh_host_model_i.access(1'b0, `BDH_RAM_BASE, {s1[15:0], s0[15:0]});
        bdh_host_model_i.access(1'b0, `BDH_STAT_ADDR, 32'h1);
        bdh_host_model_i.access(1'b1, `BDH_CTRL_ADDR, 32'h3);
        bdh_host_model_i.access(1'b0, `BDH_CTRL_ADDR, 32'h3);
        repeat (10) @(posedge clk);
        level_one_accept <= 1'b1;
        @(posedge clk);
        // Engine enters run at this edge, so the first random busy sample lands on the next one
        level_one_accept <= 1'b0;
        run_pair(s0, s1);
        bdh_host_model_i.access(1'b1, `BDH_CTRL_ADDR, 32'h0);
        bdh_host_model_i.access(1'b0, `BDH_RAM_BASE + 24'h4, {s1[15:0], s0[15:0]});
        bdh_host_model_i.access(1'b0, `BDH_STAT_ADDR, 32'h2);
        // Exactly 1024 records with busy high: pointer comes round once
        bdh_host_model_i.access(1'b1, `BDH_CTRL_ADDR, 32'h1);
        repeat (16 * 1024) @(posedge clk);
        bdh_host_model_i.access(1'b1, `BDH_CTRL_ADDR, 32'h0);
        bdh_host_model_i.access(1'b0, `BDH_STAT_ADDR, 32'h402);
        bdh_host_model_i.access(1'b0, `BDH_RAM_LAST, {16'(TC), 16'(TC)});
        bdh_host_model_i.access(1'b0, `BDH_RAM_BASE, {16'(TC), 16'(TC)});
        clear_all();
        bdh_host_model_i.access(1'b0, `BDH_RAM_BASE, 32'h0);
        bdh_host_model_i.access(1'b0, `BDH_STAT_ADDR, 32'h0);
        @(posedge clk);
        final_report();
    end
endmodule // testbench
